// file: hw/wdtgp_cfg.svh
// constants of the watchdog block: register offsets, field positions, reset values, timings
// assumes inclusion by bare name from the package and the design file
`ifndef WDTGP_CFG_SVH
`define WDTGP_CFG_SVH
`define WDTGP_ADDR_W        8
`define WDTGP_OFS_CONTROL   8'haa
`define WDTGP_OFS_TA        8'hc7
`define WDTGP_TA_KEY1       8'haa
`define WDTGP_TA_KEY2       8'h55
`define WDTGP_TA_WINDOW     3'h4
`define WDTGP_BIT_RUN       7
`define WDTGP_BIT_CLR       6
`define WDTGP_BIT_TOF       5
`define WDTGP_BIT_IDLE      4
`define WDTGP_BIT_RCF       3
`define WDTGP_PS_HI         2
`define WDTGP_PS_RESET      3'h7
`define WDTGP_CFG_GP        4'hf
`define WDTGP_CFG_STOPLP    4'h5
`define WDTGP_TICKS         7'h40
`define WDTGP_GRACE         10'h200
`define WDTGP_OSC_HZ        10000
`define WDTGP_CLK_HZ        20000000
`endif

// file: hw/wdtgp_pkg.sv
// types shared by the watchdog block
// assumes the constants header is on the include path
`include "wdtgp_cfg.svh"
package wdtgp_pkg;
    typedef struct packed {
        logic       run;
        logic       clr;
        logic       tof;
        logic       idle_run;
        logic       rcf;
        logic [2:0] ps;
    } wdtgp_ctrl_t;
    typedef enum logic [1:0] {
        WDTGP_TA_IDLE = 2'b00,
        WDTGP_TA_HALF = 2'b01,
        WDTGP_TA_OPEN = 2'b10
    } wdtgp_ta_t;
endpackage

// file: hw/wdtgp_top.sv
// watchdog / periodic timer with timed-access protected control register
// assumes CLK_IN 20 MHz, osc tick input already synchronous, one write strobe a cycle
`timescale 1ns/1ns
`include "wdtgp_cfg.svh"
module wdtgp_top #(
    parameter int GRACE_TICKS = 512
) (
    input  wire logic                      CLK_IN,
    input  wire logic                      SRST_IN,
    input  wire logic                      POR_IN,
    input  wire logic                      OSC_TICK_IN,
    input  wire logic [3:0]                CFG_ENABLE_IN,
    input  wire logic                      LOW_POWER_IN,
    input  wire logic                      WD_INT_EN_IN,
    input  wire logic                      GLOBAL_INT_EN_IN,
    input  wire logic [`WDTGP_ADDR_W-1:0]  ADDR_IN,
    input  wire logic [7:0]                WDATA_IN,
    input  wire logic                      WR_IN,
    input  wire logic                      RD_IN,
    output logic      [7:0]                RDATA_OUT,
    output logic                           IRQ_OUT,
    output logic                           WAKE_OUT,
    output logic                           SYS_RESET_OUT
);
    // ========================================================
    // timed-access unlock
    wdtgp_pkg::wdtgp_ta_t ta_state;
    logic [2:0]           ta_cnt;
    logic                 ta_write;
    logic                 ctl_write;
    assign ta_write  = WR_IN && (ADDR_IN == `WDTGP_OFS_TA);
    assign ctl_write = WR_IN && (ADDR_IN == `WDTGP_OFS_CONTROL)
                       && (ta_state == wdtgp_pkg::WDTGP_TA_OPEN);
    // protection re-arms after any one write inside the window or when the window closes
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || POR_IN) begin
            ta_state <= wdtgp_pkg::WDTGP_TA_IDLE;
            ta_cnt   <= 3'h0;
        end else begin
            case (ta_state)
                wdtgp_pkg::WDTGP_TA_IDLE: begin
                    if (ta_write && WDATA_IN == `WDTGP_TA_KEY1) begin
                        ta_state <= wdtgp_pkg::WDTGP_TA_HALF;
                    end
                end
                // idle bus cycles keep waiting; only a wrong key on the unlock port cancels
                wdtgp_pkg::WDTGP_TA_HALF: begin
                    if (ta_write && WDATA_IN == `WDTGP_TA_KEY2) begin
                        ta_state <= wdtgp_pkg::WDTGP_TA_OPEN;
                        ta_cnt   <= `WDTGP_TA_WINDOW;
                    end else if (ta_write) begin
                        ta_state <= wdtgp_pkg::WDTGP_TA_IDLE;
                    end
                end
                wdtgp_pkg::WDTGP_TA_OPEN: begin
                    ta_cnt <= ta_cnt - 3'h1;
                    if (WR_IN || ta_cnt == 3'h1) begin
                        ta_state <= wdtgp_pkg::WDTGP_TA_IDLE;
                    end
                end
                default: ta_state <= wdtgp_pkg::WDTGP_TA_IDLE;
            endcase
        end
    end

    // ========================================================
    // mode decode
    wdtgp_pkg::wdtgp_ctrl_t ctl;
    logic gp_mode;
    logic counting;
    logic lp_q;
    logic lp_edge;
    assign gp_mode = (CFG_ENABLE_IN == `WDTGP_CFG_GP);
    // reset mode ignores run and idle-run bits and needs no start
    assign counting = gp_mode
        ? (ctl.run && (!LOW_POWER_IN || ctl.idle_run))
        : (!LOW_POWER_IN || CFG_ENABLE_IN != `WDTGP_CFG_STOPLP);
    assign lp_edge = LOW_POWER_IN ^ lp_q;
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || POR_IN) lp_q <= 1'b0;
        else                   lp_q <= LOW_POWER_IN;
    end

    // ========================================================
    // control register
    logic       clr_done;
    logic       overflow;
    logic       grace_expired;
    // power-on alone touches prescale and cause flag; set beats software clear
    always_ff @(posedge CLK_IN) begin
        if (POR_IN) begin
            ctl     <= '0;
            ctl.ps  <= `WDTGP_PS_RESET;
        end else if (SRST_IN) begin
            ctl.run      <= 1'b0;
            ctl.clr      <= 1'b0;
            ctl.tof      <= 1'b0;
            ctl.idle_run <= 1'b0;
        end else begin
            if (ctl_write) begin
                ctl.run      <= WDATA_IN[`WDTGP_BIT_RUN];
                ctl.idle_run <= WDATA_IN[`WDTGP_BIT_IDLE];
                ctl.ps       <= WDATA_IN[`WDTGP_PS_HI:0];
                ctl.tof      <= WDATA_IN[`WDTGP_BIT_TOF];
                ctl.rcf      <= WDATA_IN[`WDTGP_BIT_RCF];
            end
            if (ctl_write && WDATA_IN[`WDTGP_BIT_CLR]) ctl.clr <= 1'b1;
            else if (clr_done)                         ctl.clr <= 1'b0;
            if (overflow) ctl.tof <= 1'b1;
            if (grace_expired) ctl.rcf <= 1'b1;
        end
    end

    // ========================================================
    // divider chain on the slow oscillator tick
    logic [7:0] prescaler;
    logic [6:0] count;
    logic       ps_hit;
    logic [7:0] ps_mask;
    always_comb begin
        case (ctl.ps)
            3'h0:    ps_mask = 8'h00;
            3'h1:    ps_mask = 8'h03;
            3'h2:    ps_mask = 8'h07;
            3'h3:    ps_mask = 8'h0f;
            3'h4:    ps_mask = 8'h1f;
            3'h5:    ps_mask = 8'h3f;
            3'h6:    ps_mask = 8'h7f;
            default: ps_mask = 8'hff;
        endcase
    end
    assign ps_hit   = OSC_TICK_IN && ((prescaler & ps_mask) == ps_mask);
    assign overflow = counting && ps_hit && (count == `WDTGP_TICKS - 7'h1);
    // pending clear is honoured only on an osc tick, so status shows the slow domain
    assign clr_done = ctl.clr && OSC_TICK_IN;
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || POR_IN || lp_edge || clr_done) begin
            prescaler <= 8'h00;
            count     <= 7'h00;
        end else if (counting && OSC_TICK_IN) begin
            prescaler <= (prescaler & ps_mask) == ps_mask ? 8'h00 : prescaler + 8'h01;
            if (ps_hit) count <= overflow ? 7'h00 : count + 7'h01;
        end
    end

    // ========================================================
    // grace period before watchdog reset in reset mode
    logic        grace_on;
    logic [9:0]  grace_cnt;
    assign grace_expired = grace_on && OSC_TICK_IN
                           && (grace_cnt == 10'(GRACE_TICKS - 1));
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || POR_IN || clr_done || gp_mode) begin
            grace_on  <= 1'b0;
            grace_cnt <= 10'h000;
        end else if (overflow) begin
            grace_on  <= 1'b1;
            grace_cnt <= 10'h000;
        end else if (grace_on && OSC_TICK_IN) begin
            grace_cnt <= grace_cnt + 10'h001;
        end
    end

    // ========================================================
    // outputs, all registered
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN || POR_IN) begin
            IRQ_OUT       <= 1'b0;
            WAKE_OUT      <= 1'b0;
            SYS_RESET_OUT <= 1'b0;
            RDATA_OUT     <= 8'h00;
        end else begin
            IRQ_OUT       <= ctl.tof && WD_INT_EN_IN && GLOBAL_INT_EN_IN;
            WAKE_OUT      <= overflow && LOW_POWER_IN;
            SYS_RESET_OUT <= grace_expired;
            // unmapped reads return zero
            RDATA_OUT     <= (RD_IN && ADDR_IN == `WDTGP_OFS_CONTROL) ? ctl : 8'h00;
        end
    end

    // ========================================================
    // checks
    a_clear_write_sets: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        ctl_write && WDATA_IN[`WDTGP_BIT_CLR] |=> ctl.clr)
        else $error("clear request not pending");
    a_clear_done_zero: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        clr_done && !ctl_write |=> count == 7'h00 && !ctl.clr)
        else $error("clear not completed");
    a_flag_sticky: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        ctl.tof && !ctl_write |=> ctl.tof)
        else $error("timeout flag dropped by hardware");
    a_gp_run_gate: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        gp_mode && !ctl.run && !lp_edge && !clr_done |=> $stable(count))
        else $error("counter moved while stopped");
    a_unlocked_only: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        WR_IN && ADDR_IN == `WDTGP_OFS_CONTROL && ta_state != wdtgp_pkg::WDTGP_TA_OPEN
        && !overflow && !clr_done |=> $stable(ctl.ps) && $stable(ctl.run))
        else $error("locked write took effect");
    a_no_gp_reset: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        gp_mode |-> ##1 !SYS_RESET_OUT)
        else $error("reset issued in timer mode");
    a_reset_follows: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        grace_expired |=> SYS_RESET_OUT && ctl.rcf)
        else $error("grace expiry missed");
    a_irq_gate: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        IRQ_OUT |-> $past(ctl.tof) && $past(WD_INT_EN_IN) && $past(GLOBAL_INT_EN_IN))
        else $error("interrupt without enables");
    a_lp_stop_five: assert property (@(posedge CLK_IN) disable iff (SRST_IN || POR_IN)
        CFG_ENABLE_IN == `WDTGP_CFG_STOPLP && LOW_POWER_IN && !lp_edge && !clr_done
        |=> $stable(count))
        else $error("counter ran in low power");

    // ========================================================
    // further checks
    // the unlock sequence, the slow tick gating and the grace period are the parts
    // that software exercises least, so each step of them is watched on its own;
    // all checks are quiet during either reset, since both resets rewrite state
    // that the properties compare against

    // first key moves the unlock to its second half
    a_ta_first_key: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) ta_state == wdtgp_pkg::WDTGP_TA_IDLE && ta_write
        && WDATA_IN == `WDTGP_TA_KEY1 |=> ta_state == wdtgp_pkg::WDTGP_TA_HALF)
        else $error("first unlock key ignored");

    // second key opens the window with a full count
    a_ta_second_key: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) ta_state == wdtgp_pkg::WDTGP_TA_HALF && ta_write
        && WDATA_IN == `WDTGP_TA_KEY2 |=> ta_state == wdtgp_pkg::WDTGP_TA_OPEN
        && ta_cnt == `WDTGP_TA_WINDOW)
        else $error("second unlock key ignored");

    // a wrong second key cancels the sequence
    a_ta_wrong_key: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) ta_state == wdtgp_pkg::WDTGP_TA_HALF && ta_write
        && WDATA_IN != `WDTGP_TA_KEY2 |=> ta_state == wdtgp_pkg::WDTGP_TA_IDLE)
        else $error("wrong unlock key accepted");

    // any write inside the window uses it up
    a_ta_rearm_write: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ta_state == wdtgp_pkg::WDTGP_TA_OPEN && WR_IN |=> ta_state == wdtgp_pkg::WDTGP_TA_IDLE)
        else $error("unlock not consumed");

    // the window closes on its own when no write comes
    a_ta_window_end: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) ta_state == wdtgp_pkg::WDTGP_TA_OPEN
        && ta_cnt == 3'h1 |=> ta_state == wdtgp_pkg::WDTGP_TA_IDLE)
        else $error("unlock window stayed open");

    // the window never opens without both keys
    a_ta_no_skip: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ta_state == wdtgp_pkg::WDTGP_TA_IDLE |=> ta_state != wdtgp_pkg::WDTGP_TA_OPEN)
        else $error("unlock skipped a key");

    // an unlocked write lands in the prescale field
    a_ps_write: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ctl_write |=> ctl.ps == $past(WDATA_IN[`WDTGP_PS_HI:0]))
        else $error("prescale write lost");

    // an unlocked write lands in the run bit
    a_run_write: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ctl_write |=> ctl.run == $past(WDATA_IN[`WDTGP_BIT_RUN]))
        else $error("run bit write lost");

    // writing zero to the clear bit starts nothing
    a_clear_zero_noop: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ctl_write && !WDATA_IN[`WDTGP_BIT_CLR] && !ctl.clr |=> !ctl.clr)
        else $error("clear started by a zero");

    // the pending clear waits for the slow tick
    a_clear_pending: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ctl.clr && !OSC_TICK_IN |=> ctl.clr)
        else $error("clear status dropped early");

    // overflow raises the flag
    a_flag_set: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        overflow |=> ctl.tof)
        else $error("overflow did not set flag");

    // the cause flag only leaves by software or power-on
    a_cause_sticky: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ctl.rcf && !ctl_write |=> ctl.rcf)
        else $error("reset cause dropped by hardware");

    // running timer advances by one on each divided tick
    a_gp_counts: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) gp_mode && ctl.run && !LOW_POWER_IN && ps_hit
        && !lp_edge && !clr_done && count != `WDTGP_TICKS - 7'h1
        |=> count == $past(count) + 7'h01)
        else $error("running timer did not advance");

    // reset mode advances whatever the run bit says
    a_rm_counts: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) !gp_mode && !LOW_POWER_IN && ps_hit
        && !lp_edge && !clr_done && count != `WDTGP_TICKS - 7'h1
        |=> count == $past(count) + 7'h01)
        else $error("reset mode timer did not advance");

    // timer mode without idle-run halts in low power
    a_gp_idle_stop: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN) gp_mode && LOW_POWER_IN && !ctl.idle_run
        && !lp_edge && !clr_done |=> $stable(count))
        else $error("timer ran in low power");

    // the count restarts after each interval
    a_wrap_zero: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        overflow |=> count == 7'h00)
        else $error("count did not wrap");

    // entering or leaving low power zeroes the chain
    a_lp_edge_clear: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        lp_edge |=> count == 7'h00 && prescaler == 8'h00)
        else $error("chain not cleared on power change");

    // nothing but a power change moves the count between slow ticks
    a_ticks_only: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        !OSC_TICK_IN && !lp_edge && !clr_done |=> $stable(count))
        else $error("count moved without a tick");

    // interval end in low power raises wake
    a_wake_pulse: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        overflow && LOW_POWER_IN |=> WAKE_OUT)
        else $error("wake missed");

    // wake only follows an interval end
    a_wake_cause: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        WAKE_OUT |-> $past(overflow))
        else $error("wake without interval end");

    // reset mode overflow arms the grace period from zero
    a_grace_start: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        overflow && !gp_mode && !clr_done |=> grace_on && grace_cnt == 10'h000)
        else $error("grace period not armed");

    // a completed clear calls off the pending reset
    a_clear_cancels: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        clr_done |=> !grace_on)
        else $error("clear left grace running");

    // system reset only follows the end of the grace period
    a_reset_cause: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        SYS_RESET_OUT |-> $past(grace_expired))
        else $error("system reset without grace end");

    // flag with both enables gives the interrupt
    a_irq_follows: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        ctl.tof && WD_INT_EN_IN && GLOBAL_INT_EN_IN |=> IRQ_OUT)
        else $error("interrupt missed");

    // global enable low masks the interrupt
    a_irq_global_off: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        !GLOBAL_INT_EN_IN |=> !IRQ_OUT)
        else $error("interrupt past global mask");

    // a control read returns the register one cycle later
    a_read_data: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        RD_IN && ADDR_IN == `WDTGP_OFS_CONTROL |=> RDATA_OUT == $past(ctl))
        else $error("read data wrong");

    // read data stand for one cycle only
    a_read_idle: assert property (@(posedge CLK_IN)
        disable iff (SRST_IN || POR_IN)
        !RD_IN |=> RDATA_OUT == 8'h00)
        else $error("read data held over");
endmodule

// file: verif/wdtgp_osc_model.sv
// slow oscillator model: one-cycle tick every DIV system clocks
// assumes the system clock is the same one that feeds the design
`timescale 1ns/1ns
module wdtgp_osc_model #(
    parameter int DIV = 8
) (
    input  wire logic clk_in,
    input  wire logic hold_in,
    output logic      tick_out
);
    int cnt = 0;
    initial tick_out = 1'b0;
    // ====================================
    // tick generation
    // hold freezes the oscillator so slow answers can be seen
    always @(posedge clk_in) begin
        if (hold_in) begin
            tick_out <= 1'b0;
        end else begin
            cnt      <= (cnt == DIV - 1) ? 0 : cnt + 1;
            tick_out <= (cnt == DIV - 1);
        end
    end
endmodule

// file: verif/watchdog_timer_with_gp_mode_tb_top.sv
// testbench of the watchdog block: register tasks and directed tests
// assumes the design package files are compiled first
`timescale 1ns/1ns
module watchdog_timer_with_gp_mode_tb_top;
    logic       clk, srst, por, tick, low_power, wd_ie, gl_ie, wr_in, rd_in, hold;
    logic [3:0] cfg;
    logic [7:0] addr, wdata, rdata, d;
    logic       irq, wake, sys_rst;
    int         errors = 0;
    int         compares = 0;
    int         n_rst = 0;
    int         n_wake = 0;

    wdtgp_top #(.GRACE_TICKS(4)) i_dut (.CLK_IN(clk), .SRST_IN(srst), .POR_IN(por),
        .OSC_TICK_IN(tick), .CFG_ENABLE_IN(cfg), .LOW_POWER_IN(low_power),
        .WD_INT_EN_IN(wd_ie), .GLOBAL_INT_EN_IN(gl_ie), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr_in), .RD_IN(rd_in), .RDATA_OUT(rdata), .IRQ_OUT(irq), .WAKE_OUT(wake),
        .SYS_RESET_OUT(sys_rst));
    wdtgp_osc_model #(.DIV(8)) i_osc (.clk_in(clk), .hold_in(hold), .tick_out(tick));

    // ====================================
    // clock and event counters
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (sys_rst === 1'b1) n_rst++;
        if (wake === 1'b1) n_wake++;
    end

    // ====================================
    // shared tasks; each starts and ends just after a rising edge
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr_in <= 1'b1;
        @(posedge clk);
        wr_in <= 1'b0;
        @(posedge clk);
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] q);
        addr  <= a;
        rd_in <= 1'b1;
        @(posedge clk);
        rd_in <= 1'b0;
        #1 q = rdata;
        @(posedge clk);
    endtask
    // the gap cycles stay inside the four-cycle unlock window
    task automatic unlock_wr(input logic [7:0] v);
        bus_wr(8'hc7, 8'haa);
        bus_wr(8'hc7, 8'h55);
        bus_wr(8'haa, v);
    endtask
    task automatic do_reset(input logic p);
        srst <= 1'b1;
        por  <= p;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        por  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ====================================
    // watchdog against hangs; tests need about 3000 cycles
    initial begin
        #(50 * 20000);
        errors++;
        end_sim;
    end

    // ====================================
    // directed tests
    initial begin
        {srst, por, low_power, wd_ie, gl_ie, wr_in, rd_in, hold} = '0;
        cfg = 4'hf;
        addr = 8'h00;
        wdata = 8'h00;
        do_reset(1'b1);
        bus_rd(8'haa, d); chk("ctl_por", d, 8'h07);
        bus_wr(8'haa, 8'h80);
        bus_rd(8'haa, d); chk("ctl_locked", d, 8'h07);
        $display("test access done");
        // periodic mode kept running through low power
        low_power <= 1'b1;
        wd_ie <= 1'b1;
        gl_ie <= 1'b1;
        unlock_wr(8'h90);
        for (int i = 0; i < 400; i++) begin
            bus_rd(8'haa, d);
            if (d[5] === 1'b1) break;
        end
        chk("tof", d & 8'h20, 8'h20);
        #1 chk("irq_on", {7'h00, irq}, 8'h01);
        chk("wake", {7'h00, n_wake != 0}, 8'h01);
        @(posedge clk);
        gl_ie <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("irq_off", {7'h00, irq}, 8'h00);
        @(posedge clk);
        unlock_wr(8'h10);
        repeat (600) @(posedge clk);
        bus_rd(8'haa, d); chk("halted", d, 8'h10);
        chk("no_rst", n_rst[7:0], 8'h00);
        $display("test periodic done");
        // reset mode: no start needed, grace then system reset
        cfg <= 4'h0;
        low_power <= 1'b0;
        do_reset(1'b1);
        unlock_wr(8'h00);
        for (int i = 0; i < 3000 && n_rst == 0; i++) @(posedge clk);
        chk("sys_rst", n_rst[7:0], 8'h01);
        do_reset(1'b0);
        bus_rd(8'haa, d); chk("ctl_wdrst", d, 8'h08);
        hold <= 1'b1;
        unlock_wr(8'h40);
        bus_rd(8'haa, d); chk("clr_pend", d, 8'h40);
        hold <= 1'b0;
        repeat (40) @(posedge clk);
        bus_rd(8'haa, d); chk("clr_done", d, 8'h00);
        // feeding inside the grace period avoids the system reset
        for (int i = 0; i < 400; i++) begin
            bus_rd(8'haa, d);
            if (d[5] === 1'b1) break;
        end
        chk("tof_rm", d & 8'h20, 8'h20);
        unlock_wr(8'h40);
        repeat (100) @(posedge clk);
        chk("fed", n_rst[7:0], 8'h01);
        // config five halts the watchdog in low power
        cfg <= 4'h5;
        low_power <= 1'b1;
        n_wake = 0;
        repeat (600) @(posedge clk);
        bus_rd(8'haa, d); chk("lp_stop", d, 8'h00);
        chk("lp_nowake", n_wake[7:0], 8'h00);
        $display("test reset mode done");
        end_sim;
    end
endmodule
